/* File: rtl/ppm_pkg.sv */
// Package of constants and types for the power-mode control block
package ppm_pkg;

  // Clock period in picoseconds (200 MHz)
  localparam int CLK_PERIOD_PS = 5000;

  // Power-up reset interval, longest, in ns
  localparam int POWER_UP_RESET_INTERVAL_NS = 10000;
  // Power-up reset interval in clock cycles
  localparam int POWER_UP_RESET_CYCLES = (POWER_UP_RESET_INTERVAL_NS * 1000) / CLK_PERIOD_PS;

  // Wake latency after power-down release, in ns
  localparam int WAKE_OUTPUT_LATENCY_NS = 1000;
  // Wake latency in cycles (longest time, rounded down)
  localparam int WAKE_CYCLES = (WAKE_OUTPUT_LATENCY_NS * 1000) / CLK_PERIOD_PS;

  // Slow slew adder, fastest and slowest grade, in ns
  localparam int SLOW_SLEW_ADDER_FAST_NS = 3;
  localparam int SLOW_SLEW_ADDER_SLOW_NS = 4;
  // Slow slew adder cycle counts (least time, rounded up)
  localparam int SLEW_FAST_CYCLES =
    (SLOW_SLEW_ADDER_FAST_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SLEW_SLOW_CYCLES =
    (SLOW_SLEW_ADDER_SLOW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // Reset value of macrocell registers and slew bits
  localparam logic REG_RESET_VALUE  = 1'b0;
  localparam logic SLEW_RESET_VALUE = 1'b0;

  // Operating modes
  typedef enum logic [1:0] {
    PPM_RESET,
    PPM_RUN,
    PPM_DOWN,
    PPM_WAKE
  } ppm_mode_type;

endpackage

/* File: rtl/ppm_out_if.sv */
// Interface carrying every output's data, enable and slew setting
`timescale 1ns/1ps
interface ppm_out_if #(parameter int WIDTH = 8);
  logic [WIDTH-1:0] data;  // Held output data
  logic [WIDTH-1:0] oe;    // Held output enables
  logic [WIDTH-1:0] fast;  // Fast slew selects
  logic [WIDTH-1:0] pad;   // Delayed data toward the pin
  modport core (output data, output oe, output fast, input pad);
  modport slew (input data, input oe, input fast, output pad);
endinterface

/* File: rtl/ppm_slew.sv */
// Per-output slew delay stage
`timescale 1ns/1ps
module ppm_slew
  import ppm_pkg::*;
#(
  parameter int WIDTH     = 8,
  parameter int SLOW_CYCS = SLEW_SLOW_CYCLES
) (
  input  wire logic i_clk_sys,
  input  wire logic i_rst,
  ppm_out_if.slew   bus
);

  ////////////////////////////////////////////////////////////////////////
  // One delay line per output; slow outputs see the adder delay
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_out
      // Delay line local to this output, so each has a single driver
      logic [SLOW_CYCS-1:0] line;
      // The cast keeps the shift legal when a single stage is enough
      always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
          line <= '0;
        end else begin
          line <= SLOW_CYCS'({line, bus.data[g]});
        end
      end
      // Fast path bypasses the line; slow path uses its last tap
      assign bus.pad[g] = bus.fast[g] ? bus.data[g] : line[SLOW_CYCS-1];
    end
  endgenerate

endmodule

/* File: rtl/ppm_core.sv */
// Power-down, power-up reset, preload and slew control core
`timescale 1ns/1ps
module ppm_core
  import ppm_pkg::*;
#(
  parameter int   WIDTH       = 8,
  parameter bit   PD_ENABLE   = 1'b1,
  parameter int   RST_CYCLES  = POWER_UP_RESET_CYCLES,
  parameter int   WAKE_CYCS   = WAKE_CYCLES
) (
  input  wire logic             i_clk_sys,
  input  wire logic             i_rst,
  input  wire logic             i_power_down_pin,
  input  wire logic [WIDTH-1:0] i_pin_in,
  input  wire logic [WIDTH-1:0] i_next_data,
  input  wire logic [WIDTH-1:0] i_next_oe,
  input  wire logic             i_reg_clk_en,
  input  wire logic [WIDTH-1:0] i_fast_slew,
  input  wire logic             i_preload_hv,
  input  wire logic [WIDTH-1:0] i_preload_sel,
  input  wire logic [WIDTH-1:0] i_preload_val,
  output logic      [WIDTH-1:0] o_pin_held,
  output logic      [WIDTH-1:0] o_reg_q,
  output logic      [WIDTH-1:0] o_pad_data,
  output logic      [WIDTH-1:0] o_pad_oe,
  output logic                  o_power_down,
  output logic                  o_reset_busy,
  output logic                  o_wake_busy,
  output logic                  o_pd_pin_logic
);

  // Mode of the block
  ppm_mode_type mode;
  // Cycle counter for reset and wake intervals
  logic [31:0]  cnt;
  // Power-down request, gated by the static option
  logic         pd_req;
  // Input gate: pin, data, enable and clock inputs are honoured only while running or waking
  logic         live;
  // Output path toward the slew stage
  ppm_out_if #(.WIDTH(WIDTH)) ob ();

  assign pd_req = PD_ENABLE && i_power_down_pin;
  assign live   = (mode == PPM_RUN) || (mode == PPM_WAKE);

  ////////////////////////////////////////////////////////////////////////
  // Mode sequencing: reset interval, run, power-down, wake
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      mode <= PPM_RESET;
      cnt  <= '0;
    end else begin
      case (mode)
        PPM_RESET: begin
          // Long interval; parameter shortens it in simulation
          if (cnt >= 32'(RST_CYCLES - 1)) begin
            mode <= PPM_RUN;
            cnt  <= '0;
          end else begin
            cnt <= cnt + 32'd1;
          end
        end
        PPM_RUN: begin
          if (pd_req) begin
            mode <= PPM_DOWN;
          end
        end
        PPM_DOWN: begin
          if (!pd_req) begin
            mode <= PPM_WAKE;
            cnt  <= '0;
          end
        end
        PPM_WAKE: begin
          // Busy flag tells the board when it may count on the pins
          if (pd_req) begin
            mode <= PPM_DOWN;
          end else if (cnt >= 32'(WAKE_CYCS - 1)) begin
            mode <= PPM_RUN;
          end else begin
            cnt <= cnt + 32'd1;
          end
        end
        default: begin
          mode <= PPM_RESET;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Macrocell registers: reset low, preload, normal clocked load
  always_ff @(posedge i_clk_sys) begin
    if (i_rst || mode == PPM_RESET) begin
      o_reg_q <= {WIDTH{REG_RESET_VALUE}};
    end else if (i_preload_hv) begin
      // Preload only under the tester's high-voltage strobe
      o_reg_q <= (o_reg_q & ~i_preload_sel) | (i_preload_val & i_preload_sel);
    end else if (live && !pd_req && i_reg_clk_en) begin
      o_reg_q <= i_next_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Input hold latches keep last level; frozen in power-down
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_pin_held <= '0;
    end else if (live && !pd_req) begin
      o_pin_held <= i_pin_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output enables freeze too, so high-Z stays high-Z
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      ob.oe <= '0;
    end else if (live && !pd_req) begin
      ob.oe <= i_next_oe;
    end
  end

  // Slew bits: slow unless the design sets fast
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      ob.fast <= {WIDTH{SLEW_RESET_VALUE}};
    end else begin
      ob.fast <= i_fast_slew;
    end
  end

  assign ob.data = o_reg_q;

  // Slew delay stage
  ppm_slew #(.WIDTH(WIDTH), .SLOW_CYCS(SLEW_SLOW_CYCLES)) u_slew (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .bus       (ob)
  );

  ////////////////////////////////////////////////////////////////////////
  // Registered pin drive and status outputs
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_pad_data     <= '0;
      o_pad_oe       <= '0;
      o_power_down   <= 1'b0;
      o_reset_busy   <= 1'b1;
      o_wake_busy    <= 1'b0;
      o_pd_pin_logic <= 1'b0;
    end else begin
      if (mode != PPM_DOWN) begin
        o_pad_data <= ob.pad;
        o_pad_oe   <= ob.oe;
      end
      o_power_down   <= (mode == PPM_DOWN);
      o_reset_busy   <= (mode == PPM_RESET);
      o_wake_busy    <= (mode == PPM_WAKE);
      // With the option on, the pin never reaches the array
      o_pd_pin_logic <= PD_ENABLE ? 1'b0 : i_power_down_pin;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Assertions
  property p_pd_enter;
    @(posedge i_clk_sys) disable iff (i_rst)
      (mode == PPM_RUN && pd_req) |=> (mode == PPM_DOWN);
  endproperty
  a_pd_enter: assert property (p_pd_enter) else $error("power-down not entered");

  property p_hold_reg;
    @(posedge i_clk_sys) disable iff (i_rst)
      (mode == PPM_DOWN && !i_preload_hv) |=> $stable(o_reg_q);
  endproperty
  a_hold_reg: assert property (p_hold_reg) else $error("register moved in power-down");

  property p_hold_oe;
    @(posedge i_clk_sys) disable iff (i_rst)
      (o_power_down && $past(o_power_down)) |-> $stable(o_pad_oe);
  endproperty
  a_hold_oe: assert property (p_hold_oe) else $error("enable changed in power-down");

  property p_hold_pin;
    @(posedge i_clk_sys) disable iff (i_rst)
      (mode == PPM_DOWN) |=> $stable(o_pin_held);
  endproperty
  a_hold_pin: assert property (p_hold_pin) else $error("input latched in power-down");

  property p_pin_logic;
    @(posedge i_clk_sys) disable iff (i_rst)
      PD_ENABLE |=> !o_pd_pin_logic;
  endproperty
  a_pin_logic: assert property (p_pin_logic) else $error("pin reached logic");

  property p_reset_low;
    @(posedge i_clk_sys) disable iff (i_rst)
      (mode == PPM_RESET) |=> (o_reg_q == '0);
  endproperty
  a_reset_low: assert property (p_reset_low) else $error("register not low in reset");

  property p_preload;
    @(posedge i_clk_sys) disable iff (i_rst)
      (i_preload_hv && mode != PPM_RESET) |=>
        ((o_reg_q & $past(i_preload_sel)) == ($past(i_preload_val) & $past(i_preload_sel)));
  endproperty
  a_preload: assert property (p_preload) else $error("preload not applied");

  property p_wake;
    @(posedge i_clk_sys) disable iff (i_rst)
      (mode == PPM_DOWN && !pd_req && !i_preload_hv) |=>
        (mode == PPM_WAKE) ##0 $stable(o_reg_q);
  endproperty
  a_wake: assert property (p_wake) else $error("wake lost state");

endmodule

/* File: test/ppm_board.sv */
// Board-side model that paces register clocks around reset and wake
`timescale 1ns/1ps
module ppm_board (
  input  wire logic i_en_req,     // Clock request from the bench
  input  wire logic i_reset_busy, // Power-up reset still running
  input  wire logic i_wake_busy,  // Wake interval still running
  output logic      o_reg_clk_en  // Clock pulse seen by the device
);
  // Board never clocks registers inside the reset or wake window
  assign o_reg_clk_en = i_en_req & ~i_reset_busy & ~i_wake_busy;
endmodule

/* File: test/pld_power_mode_control_bench.sv */
// Self-checking bench for the power-mode control core
`timescale 1ns/1ps
module pld_power_mode_control_bench;
  import ppm_pkg::*;
  typedef struct {logic [35:0] v; logic [35:0] m;} ppm_note_type;
  // Field masks over {flags, pin_held, reg_q, pad, oe}
  localparam logic [35:0] MF = 36'hF_0000_0000;
  localparam logic [35:0] MQ = 36'h0_00FF_0000;
  localparam logic [35:0] MP = 36'h0_0000_FF00;
  localparam logic [35:0] MA = 36'hF_FFFF_FFFF;
  logic         clk = 0, rst = 1, pd = 0, en_req = 0, en, hv = 0;
  logic   [7:0] pin = 0, nd = 0, noe = 8'hA5, fast = 0, sel = 0, val = 0;
  logic   [7:0] held, q, pad, oe, d;
  logic         rb, pdo, wb, pl;
  int           n_mismatch = 0, check_count = 0, seed = 98;
  ppm_note_type notes[$], nt;

  ////////////////////////////////////////////////////////////////////////
  // Short counts keep the run brief
  ppm_core #(.WIDTH(8), .PD_ENABLE(1'b1), .RST_CYCLES(8), .WAKE_CYCS(4)) i_dut (
    .i_clk_sys(clk), .i_rst(rst), .i_power_down_pin(pd), .i_pin_in(pin),
    .i_next_data(nd), .i_next_oe(noe), .i_reg_clk_en(en), .i_fast_slew(fast),
    .i_preload_hv(hv), .i_preload_sel(sel), .i_preload_val(val),
    .o_pin_held(held), .o_reg_q(q), .o_pad_data(pad), .o_pad_oe(oe),
    .o_power_down(pdo), .o_reset_busy(rb), .o_wake_busy(wb), .o_pd_pin_logic(pl));
  ppm_board i_board (.i_en_req(en_req), .i_reset_busy(rb), .i_wake_busy(wb),
    .o_reg_clk_en(en));

  // 200 MHz clock
  always #2.5 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic note(input logic [35:0] v, input logic [35:0] m);
    notes.push_back('{v, m});
  endtask
  task automatic check(input string nm, input logic [35:0] seen, input logic [35:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic results;
    $display("Checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Monitor settles 1 ns past the drive edge so outputs are stable
  always @(negedge clk) begin
    #1;
    while (notes.size() > 0) begin
      nt = notes.pop_front();
      check("outputs", {rb, pdo, wb, pl, held, q, pad, oe} & nt.m, nt.v & nt.m);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    cyc(4);
    note({4'b1000, 32'h0}, MA);
    rst = 0;
    cyc(12);
    note(36'h0, MF | MQ);
    d = 8'($random(seed));
    pin = 8'($random(seed));
    nd = d;
    fast = 8'h0F;
    en_req = 1;
    cyc(1);
    en_req = 0;
    note({12'h0, d, 16'h0}, MQ);
    cyc(1);
    note({20'h0, 4'h0, d[3:0], 8'h0}, MP);
    cyc(1);
    note({4'h0, pin, d, d, noe}, MA);
    // Preload each half high and low; high voltage absent first
    for (int k = 0; k < 2; k++) begin
      sel = k ? 8'h0F : 8'hF0;
      val = 8'($random(seed));
      hv = 0;
      cyc(1);
      note({12'h0, d, 16'h0}, MQ);
      hv = 1;
      cyc(1);
      hv = 0;
      d = (d & ~sel) | (val & sel);
      note({12'h0, d, 16'h0}, MQ);
    end
    cyc(3);
    pd = 1;
    cyc(3);
    note({4'b0100, pin, d, d, noe}, MA);
    // Toggle next data, clock request, pins and enables while frozen; nothing may move
    nd = ~d;
    en_req = 1;
    pin = ~pin;
    noe = ~noe;
    cyc(4);
    note({4'b0100, ~pin, d, d, ~noe}, MA);
    en_req = 0;
    noe = ~noe;
    pd = 0;
    cyc(3);
    note({4'b0010, 32'h0}, MF);
    cyc(8);
    note({4'b0000, pin, d, d, noe}, MA);
    nd = 8'($random(seed));
    en_req = 1;
    cyc(1);
    en_req = 0;
    note({12'h0, nd, 16'h0}, MQ);
    // Reset again in mid-run
    rst = 1;
    cyc(2);
    note({4'b1000, 32'h0}, MA);
    rst = 0;
    cyc(12);
    note(36'h0, MF | MQ);
    cyc(2);
    results();
  end

  // Watchdog well past the expected run length
  initial begin
    repeat (1000) @(posedge clk);
    n_mismatch++;
    results();
  end
endmodule
